// *** core/tcs_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none

module tcs_sequencer #(
  parameter int unsigned LOCAL_CYC = tcs_pkg::TCS_LOCAL_CYC,
  parameter int unsigned REMOTE_CYC = tcs_pkg::TCS_REMOTE_CYC,
  parameter int unsigned RATE1_CYC = tcs_pkg::TCS_RATE1_CYC,
  parameter int unsigned RATE2_CYC = tcs_pkg::TCS_RATE2_CYC,
  parameter int unsigned RATE3_CYC = tcs_pkg::TCS_RATE3_CYC
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET,
  // Register access by command byte.
  input wire tcs_pkg::tcs_req_s REG_REQ,
  output logic [7:0] REG_RDATA,
  // Conversion control towards the front end.
  output logic [2:0] CONV_SEL,
  output logic [1:0] CONV_FILTER,
  output logic BUSY
);
  import tcs_pkg::*;

  logic [1:0] interval_select;
  logic [2:0] conv_en;
  logic [3:0] filter_mode;
  logic sw_standby;
  logic [7:0] rdata;
  logic [1:0] next_interval_select;
  logic [2:0] next_conv_en;
  logic [3:0] next_filter_mode;
  logic next_sw_standby;
  logic [7:0] next_rdata;
  logic oneshot_wr;

  tcs_state_e state;
  tcs_state_e next_state;
  logic [1:0] cur_ch;
  logic [1:0] next_cur_ch;
  logic [31:0] conv_cnt;
  logic [31:0] next_conv_cnt;
  logic [31:0] itv_cnt;
  logic [31:0] next_itv_cnt;
  logic [2:0] snap_en;
  logic [2:0] next_snap_en;
  logic [3:0] snap_filt;
  logic [3:0] next_snap_filt;
  logic single;
  logic next_single;
  logic [2:0] conv_sel;
  logic [2:0] next_conv_sel;
  logic [1:0] conv_filter;
  logic [1:0] next_conv_filter;
  logic busy;
  logic next_busy;
  logic [31:0] ival_cyc;
  logic [31:0] conv_len;
  logic itv_done;
  logic begin_seq;
  logic seq_single;
  logic [1:0] first_ch;
  logic [1:0] after_ch;

  // Lowest enabled channel at or above a starting index.
  function automatic logic [1:0] first_from(input logic [2:0] m, input logic [1:0] from);
    logic [1:0] r;
    r = TCS_CH_NONE;
    for (int i = 2; i >= 0; i--) begin
      if (m[i] && (2'(i) >= from)) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : first_from

  function automatic logic [1:0] filt_of(input logic [3:0] f, input logic [1:0] ch);
    logic [1:0] r;
    r = TCS_FILT_OFF;
    if (ch == TCS_CH_REMOTE1) begin
      r = f[TCS_FILT_R1_LSB +: 2];
    end else if (ch == TCS_CH_REMOTE2) begin
      r = f[TCS_FILT_R2_LSB +: 2];
    end
    return r;
  endfunction : filt_of

  // Register writes and reads.
  always_comb begin
    next_interval_select = interval_select;
    next_conv_en = conv_en;
    next_filter_mode = filter_mode;
    next_sw_standby = sw_standby;
    next_rdata = rdata;
    oneshot_wr = 1'b0;
    if (REG_REQ.wr) begin
      if (REG_REQ.addr == TCS_ADDR_CONFIG) begin
        next_sw_standby = REG_REQ.wdata[TCS_STANDBY_BIT];
      end else if (REG_REQ.addr == TCS_ADDR_RATE) begin
        next_interval_select = REG_REQ.wdata[TCS_RATE_LSB +: TCS_RATE_W];
      end else if (REG_REQ.addr == TCS_ADDR_ENABLE) begin
        next_conv_en = REG_REQ.wdata[TCS_EN_LSB +: TCS_EN_W];
      end else if (REG_REQ.addr == TCS_ADDR_FILTER) begin
        next_filter_mode = REG_REQ.wdata[TCS_FILT_LSB +: TCS_FILT_W];
      end else if (REG_REQ.addr == TCS_ADDR_ONESHOT) begin
        oneshot_wr = 1'b1;
      end
    end
    if (REG_REQ.rd) begin
      next_rdata = 8'h00;
      if (REG_REQ.addr == TCS_ADDR_STATUS) begin
        next_rdata[TCS_BUSY_BIT] = busy;
      end else if (REG_REQ.addr == TCS_ADDR_CONFIG) begin
        next_rdata[TCS_STANDBY_BIT] = sw_standby;
      end else if (REG_REQ.addr == TCS_ADDR_RATE) begin
        next_rdata[TCS_RATE_LSB +: TCS_RATE_W] = interval_select;
      end else if (REG_REQ.addr == TCS_ADDR_ENABLE) begin
        next_rdata[TCS_EN_LSB +: TCS_EN_W] = conv_en;
      end else if (REG_REQ.addr == TCS_ADDR_FILTER) begin
        next_rdata[TCS_FILT_LSB +: TCS_FILT_W] = filter_mode;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      interval_select <= TCS_RATE_RST[TCS_RATE_LSB +: TCS_RATE_W];
      conv_en <= TCS_ENABLE_RST[TCS_EN_LSB +: TCS_EN_W];
      filter_mode <= TCS_FILTER_RST[TCS_FILT_LSB +: TCS_FILT_W];
      sw_standby <= TCS_CONFIG_RST[TCS_STANDBY_BIT];
      rdata <= 8'h00;
    end else begin
      interval_select <= next_interval_select;
      conv_en <= next_conv_en;
      filter_mode <= next_filter_mode;
      sw_standby <= next_sw_standby;
      rdata <= next_rdata;
    end
  end

  // Interval length; zero means continuous.
  always_comb begin
    ival_cyc = 32'h0000_0000;
    if (interval_select == TCS_RATE_0364) begin
      ival_cyc = RATE1_CYC;
    end else if (interval_select == TCS_RATE_1000) begin
      ival_cyc = RATE2_CYC;
    end else if (interval_select == TCS_RATE_2500) begin
      ival_cyc = RATE3_CYC;
    end
  end

  assign conv_len = (cur_ch == TCS_CH_LOCAL) ? LOCAL_CYC : REMOTE_CYC;
  assign itv_done = (ival_cyc == 32'h0000_0000) || (itv_cnt >= ival_cyc - 32'h0000_0001);
  assign first_ch = first_from(conv_en, TCS_CH_LOCAL);
  assign after_ch = first_from(snap_en, 2'(cur_ch + 2'h1));

  // Sequencer.
  always_comb begin
    next_state = state;
    next_cur_ch = cur_ch;
    next_conv_cnt = conv_cnt;
    next_itv_cnt = (itv_cnt == 32'hFFFF_FFFF) ? itv_cnt : itv_cnt + 32'h0000_0001;
    next_snap_en = snap_en;
    next_snap_filt = snap_filt;
    next_single = single;
    begin_seq = 1'b0;
    seq_single = 1'b0;
    case (state)
      TCS_IDLE: begin
        if (!sw_standby) begin
          begin_seq = 1'b1;
        end else if (oneshot_wr) begin
          begin_seq = 1'b1;
          seq_single = 1'b1;
        end
      end
      TCS_CONV: begin
        if (conv_cnt >= conv_len - 32'h0000_0001) begin
          next_conv_cnt = 32'h0000_0000;
          if (after_ch != TCS_CH_NONE) begin
            next_cur_ch = after_ch;
          end else if (single || sw_standby) begin
            next_state = TCS_IDLE;
          end else if (ival_cyc == 32'h0000_0000) begin
            begin_seq = 1'b1;
          end else begin
            next_state = TCS_STANDBY;
          end
        end else begin
          next_conv_cnt = conv_cnt + 32'h0000_0001;
        end
      end
      TCS_STANDBY: begin
        if (sw_standby) begin
          next_state = TCS_IDLE;
        end else if (itv_done) begin
          begin_seq = 1'b1;
        end
      end
      default: begin
        next_state = TCS_IDLE;
      end
    endcase
    if (begin_seq) begin
      next_itv_cnt = 32'h0000_0000;
      next_snap_en = conv_en;
      next_snap_filt = filter_mode;
      next_single = seq_single;
      next_conv_cnt = 32'h0000_0000;
      if (first_ch != TCS_CH_NONE) begin
        next_state = TCS_CONV;
        next_cur_ch = first_ch;
      end else if (seq_single || ival_cyc == 32'h0000_0000) begin
        next_state = TCS_IDLE;
      end else begin
        next_state = TCS_STANDBY;
      end
    end
    next_busy = (next_state == TCS_CONV);
    next_conv_sel = (next_state == TCS_CONV) ? 3'(3'h1 << next_cur_ch) : 3'h0;
    next_conv_filter = filt_of(next_snap_filt, next_cur_ch);
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state <= TCS_IDLE;
      cur_ch <= TCS_CH_LOCAL;
      conv_cnt <= 32'h0000_0000;
      itv_cnt <= 32'h0000_0000;
      snap_en <= 3'h0;
      snap_filt <= 4'h0;
      single <= 1'b0;
      conv_sel <= 3'h0;
      conv_filter <= 2'h0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cur_ch <= next_cur_ch;
      conv_cnt <= next_conv_cnt;
      itv_cnt <= next_itv_cnt;
      snap_en <= next_snap_en;
      snap_filt <= next_snap_filt;
      single <= next_single;
      conv_sel <= next_conv_sel;
      conv_filter <= next_conv_filter;
      busy <= next_busy;
    end
  end

  assign REG_RDATA = rdata;
  assign CONV_SEL = conv_sel;
  assign CONV_FILTER = conv_filter;
  assign BUSY = busy;

  // Checks.
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_oneshot_in_standby;
    state == TCS_IDLE && sw_standby && REG_REQ.wr && REG_REQ.addr == TCS_ADDR_ONESHOT;
  endsequence

  property p_rate_readback;
    REG_REQ.rd && REG_REQ.addr == TCS_ADDR_RATE |=> REG_RDATA[7:2] == 6'h00;
  endproperty
  a_rate_readback: assert property (p_rate_readback)
    else $error("rate register upper bits not zero");

  property p_enable_readback;
    REG_REQ.wr && REG_REQ.addr == TCS_ADDR_ENABLE && !REG_REQ.rd ##1 !REG_REQ.wr ##1
      REG_REQ.rd && REG_REQ.addr == TCS_ADDR_ENABLE && !REG_REQ.wr
      |=> REG_RDATA == {5'h00, $past(REG_REQ.wdata[2:0], 3)};
  endproperty
  a_enable_readback: assert property (p_enable_readback)
    else $error("enable register readback mismatch");

  property p_oneshot_starts;
    s_oneshot_in_standby and (conv_en != 3'h0) |=> BUSY && single;
  endproperty
  a_oneshot_starts: assert property (p_oneshot_starts)
    else $error("one-shot did not start a sequence");

  property p_oneshot_ignored_active;
    state == TCS_STANDBY |=> state != TCS_CONV || $past(itv_done && !sw_standby);
  endproperty
  a_oneshot_ignored_active: assert property (p_oneshot_ignored_active)
    else $error("conversion began before interval end");

  property p_oneshot_not_stored;
    REG_REQ.wr && REG_REQ.addr == TCS_ADDR_ONESHOT
      |=> $stable(interval_select) && $stable(conv_en) && $stable(filter_mode) && $stable(sw_standby);
  endproperty
  a_oneshot_not_stored: assert property (p_oneshot_not_stored)
    else $error("one-shot write changed stored state");

  property p_standby_halts;
    sw_standby && state == TCS_IDLE && !(REG_REQ.wr && REG_REQ.addr == TCS_ADDR_ONESHOT)
      |=> !BUSY;
  endproperty
  a_standby_halts: assert property (p_standby_halts)
    else $error("conversion began in standby without one-shot");

  property p_busy_tracks;
    BUSY == (state == TCS_CONV) && (CONV_SEL != 3'h0) == BUSY;
  endproperty
  a_busy_tracks: assert property (p_busy_tracks)
    else $error("busy does not match conversion state");

  property p_skip_disabled;
    BUSY |-> $onehot(CONV_SEL) && ((CONV_SEL & ~snap_en) == 3'h0);
  endproperty
  a_skip_disabled: assert property (p_skip_disabled)
    else $error("disabled channel converted");

  property p_filter_held;
    BUSY && $stable(CONV_SEL) && $past(BUSY) && !$past(begin_seq) |-> $stable(CONV_FILTER);
  endproperty
  a_filter_held: assert property (p_filter_held)
    else $error("filter mode changed inside a conversion");

  property p_timed_standby;
    state == TCS_CONV && conv_cnt >= conv_len - 32'h0000_0001 && after_ch == TCS_CH_NONE
      && !single && !sw_standby && ival_cyc != 32'h0000_0000 |=> state == TCS_STANDBY;
  endproperty
  a_timed_standby: assert property (p_timed_standby)
    else $error("timed mode did not enter standby");

  property p_continuous_restart;
    state == TCS_CONV && conv_cnt >= conv_len - 32'h0000_0001 && after_ch == TCS_CH_NONE
      && !single && !sw_standby && ival_cyc == 32'h0000_0000 && conv_en != 3'h0
      |=> state == TCS_CONV && itv_cnt == 32'h0000_0000;
  endproperty
  a_continuous_restart: assert property (p_continuous_restart)
    else $error("continuous mode did not restart at once");

  property p_interval_restart;
    state == TCS_STANDBY && !sw_standby && itv_done && conv_en != 3'h0
      |=> BUSY && itv_cnt == 32'h0000_0000;
  endproperty
  a_interval_restart: assert property (p_interval_restart)
    else $error("sequence did not restart at interval end");

endmodule : tcs_sequencer

`default_nettype wire

// *** core/tcs_pkg.sv ***
package tcs_pkg;

  // Register command bytes.
  localparam logic [7:0] TCS_ADDR_STATUS = 8'h02;
  localparam logic [7:0] TCS_ADDR_CONFIG = 8'h03;
  localparam logic [7:0] TCS_ADDR_RATE = 8'h04;
  localparam logic [7:0] TCS_ADDR_ENABLE = 8'h05;
  localparam logic [7:0] TCS_ADDR_FILTER = 8'h06;
  localparam logic [7:0] TCS_ADDR_ONESHOT = 8'h0F;

  // Field positions.
  localparam int TCS_STANDBY_BIT = 6;
  localparam int TCS_BUSY_BIT = 7;
  localparam int TCS_RATE_LSB = 0;
  localparam int TCS_RATE_W = 2;
  localparam int TCS_EN_LSB = 0;
  localparam int TCS_EN_W = 3;
  localparam int TCS_FILT_LSB = 0;
  localparam int TCS_FILT_W = 4;
  localparam int TCS_FILT_R1_LSB = 0;
  localparam int TCS_FILT_R2_LSB = 2;

  // Reset values.
  localparam logic [7:0] TCS_CONFIG_RST = 8'h00;
  localparam logic [7:0] TCS_RATE_RST = 8'h02;
  localparam logic [7:0] TCS_ENABLE_RST = 8'h1F;
  localparam logic [7:0] TCS_FILTER_RST = 8'h0F;

  // Rate codes, channel numbers and the filter-off code.
  localparam logic [1:0] TCS_RATE_CONT = 2'h0;
  localparam logic [1:0] TCS_RATE_0364 = 2'h1;
  localparam logic [1:0] TCS_RATE_1000 = 2'h2;
  localparam logic [1:0] TCS_RATE_2500 = 2'h3;
  localparam logic [1:0] TCS_CH_LOCAL = 2'h0;
  localparam logic [1:0] TCS_CH_REMOTE1 = 2'h1;
  localparam logic [1:0] TCS_CH_REMOTE2 = 2'h2;
  localparam logic [1:0] TCS_CH_NONE = 2'h3;
  localparam logic [1:0] TCS_FILT_OFF = 2'h0;

  // Timing in microseconds and the derived cycle counts.
  localparam int unsigned TCS_CLK_MHZ = 200;
  localparam int unsigned TCS_T_LOCAL_US = 30000;
  localparam int unsigned TCS_T_REMOTE_US = 37000;
  localparam int unsigned TCS_T_RATE1_US = 364000;
  localparam int unsigned TCS_T_RATE2_US = 1000000;
  localparam int unsigned TCS_T_RATE3_US = 2500000;
  localparam int unsigned TCS_LOCAL_CYC = TCS_T_LOCAL_US * TCS_CLK_MHZ;
  localparam int unsigned TCS_REMOTE_CYC = TCS_T_REMOTE_US * TCS_CLK_MHZ;
  localparam int unsigned TCS_RATE1_CYC = TCS_T_RATE1_US * TCS_CLK_MHZ;
  localparam int unsigned TCS_RATE2_CYC = TCS_T_RATE2_US * TCS_CLK_MHZ;
  localparam int unsigned TCS_RATE3_CYC = TCS_T_RATE3_US * TCS_CLK_MHZ;

  typedef enum logic [1:0] {
    TCS_IDLE = 2'b00,
    TCS_CONV = 2'b01,
    TCS_STANDBY = 2'b11
  } tcs_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcs_req_s;

endpackage : tcs_pkg

// *** sim/tcs_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module tcs_host_model (
  // Clock.
  input wire logic MCLK,
  // Register access.
  output var tcs_pkg::tcs_req_s REG_REQ,
  input wire logic [7:0] REG_RDATA
);
  import tcs_pkg::*;

  initial begin
    REG_REQ = '0;
  end

  // One access: drive after an edge, hold through the taking edge, then release.
  task automatic issue(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    #1 REG_REQ = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge MCLK);
    #1 REG_REQ = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : issue

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // A reserved filter code is never sent to the device.
    if (a == TCS_ADDR_FILTER && (d[3:2] == 2'b10 || d[1:0] == 2'b10)) begin
      return;
    end
    issue(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    issue(1'b0, a, 8'h00);
    d = REG_RDATA;
  endtask : rd

endmodule : tcs_host_model

`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import tcs_pkg::*;

  localparam int unsigned L_CYC = 5;
  localparam int unsigned R_CYC = 7;
  localparam int unsigned RATE1 = 40;
  localparam int unsigned RATE2 = 60;
  localparam int unsigned RATE3 = 90;

  logic mclk;
  logic reset;
  tcs_req_s reg_req;
  logic [7:0] reg_rdata;
  logic [2:0] conv_sel;
  logic [1:0] conv_filter;
  logic busy;
  int error_cnt;
  int checks_done;
  int unsigned cyc = 0;
  int unsigned t0;
  int k;
  logic [31:0] n;
  logic [1:0] fc;
  logic [1:0] fcode [3] = '{2'b00, 2'b01, 2'b11};

  tcs_sequencer #(.LOCAL_CYC(L_CYC), .REMOTE_CYC(R_CYC), .RATE1_CYC(RATE1),
    .RATE2_CYC(RATE2), .RATE3_CYC(RATE3)) uut (
    .MCLK(mclk),
    .RESET(reset),
    .REG_REQ(reg_req),
    .REG_RDATA(reg_rdata),
    .CONV_SEL(conv_sel),
    .CONV_FILTER(conv_filter),
    .BUSY(busy)
  );

  tcs_host_model host (.MCLK(mclk), .REG_REQ(reg_req), .REG_RDATA(reg_rdata));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
  end

  function automatic int unsigned rate_cyc(input int code);
    case (code)
      1: return RATE1;
      2: return RATE2;
      default: return RATE3;
    endcase
  endfunction : rate_cyc

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 400 && busy !== v; i++) begin
      tick();
    end
    if (busy !== v) begin
      error_cnt++;
      close_out();
    end
  endtask : wait_busy

  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    cmp({24'h00_0000, d}, {24'h00_0000, exp});
  endtask : rd_cmp

  task automatic quiet(input int cycles, output logic [31:0] seen);
    seen = '0;
    repeat (cycles) begin
      tick();
      if (busy !== 1'b0) begin
        seen++;
      end
    end
  endtask : quiet

  // Follows one sequence from its first cycle, channel by channel.
  task automatic chk_seq(input logic [2:0] en, input logic [3:0] f, input logic gap);
    int ch;
    logic [1:0] ef;
    for (ch = 0; ch < 3; ch++) begin
      if (en[ch]) begin
        ef = (ch == 0) ? 2'b00 : (ch == 1) ? f[1:0] : f[3:2];
        cmp({28'h000_0000, busy, conv_sel}, {28'h000_0000, 1'b1, 3'(1 << ch)});
        cmp({30'h0000_0000, conv_filter}, {30'h0000_0000, ef});
        repeat ((ch == 0) ? L_CYC : R_CYC) tick();
      end
    end
    if (gap) begin
      cmp({28'h000_0000, busy, conv_sel}, 32'h0000_0000);
    end
  endtask : chk_seq

  initial begin
    reset = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    repeat (3) @(posedge mclk);
    #1 reset = 1'b0;
    wait_busy(1'b1);
    t0 = cyc;
    chk_seq(3'b111, 4'hF, 1'b1);
    rd_cmp(TCS_ADDR_RATE, 8'h02);
    rd_cmp(TCS_ADDR_ENABLE, 8'h07);
    rd_cmp(TCS_ADDR_FILTER, 8'h0F);
    rd_cmp(TCS_ADDR_CONFIG, 8'h00);
    rd_cmp(TCS_ADDR_STATUS, 8'h00);
    rd_cmp(8'h10, 8'h00);
    wait_busy(1'b1);
    cmp(cyc - t0, RATE2);
    host.wr(TCS_ADDR_CONFIG, 8'hFF);
    wait_busy(1'b0);
    rd_cmp(TCS_ADDR_CONFIG, 8'h40);
    host.wr(TCS_ADDR_RATE, 8'hFF);
    host.wr(TCS_ADDR_ENABLE, 8'hFF);
    host.wr(TCS_ADDR_FILTER, 8'hFF);
    rd_cmp(TCS_ADDR_RATE, 8'h03);
    rd_cmp(TCS_ADDR_ENABLE, 8'h07);
    rd_cmp(TCS_ADDR_FILTER, 8'h0F);
    quiet(100, n);
    cmp(n, 0);
    // Settings changed during a sequence must not disturb it.
    host.wr(TCS_ADDR_ONESHOT, 8'hA5);
    wait_busy(1'b1);
    fork
      chk_seq(3'b111, 4'hF, 1'b1);
      begin
        host.wr(TCS_ADDR_ENABLE, 8'h02);
        host.wr(TCS_ADDR_FILTER, 8'h00);
      end
    join
    rd_cmp(TCS_ADDR_ONESHOT, 8'h00);
    rd_cmp(TCS_ADDR_ENABLE, 8'h02);
    host.wr(TCS_ADDR_ONESHOT, 8'h00);
    wait_busy(1'b1);
    chk_seq(3'b010, 4'h0, 1'b1);
    quiet(40, n);
    cmp(n, 0);
    for (k = 1; k < 8; k++) begin
      fc = fcode[k % 3];
      host.wr(TCS_ADDR_ENABLE, 8'(k));
      host.wr(TCS_ADDR_FILTER, {4'h0, fc, fc});
      host.wr(TCS_ADDR_ONESHOT, 8'(k));
      wait_busy(1'b1);
      chk_seq(3'(k), {fc, fc}, 1'b1);
    end
    // Timed modes with one channel keep the full interval.
    host.wr(TCS_ADDR_ENABLE, 8'h02);
    rd_cmp(TCS_ADDR_ENABLE, 8'h02);
    for (k = 1; k < 4; k++) begin
      host.wr(TCS_ADDR_RATE, 8'(k));
      host.wr(TCS_ADDR_CONFIG, 8'h00);
      wait_busy(1'b0);
      wait_busy(1'b1);
      t0 = cyc;
      chk_seq(3'b010, 4'h5, 1'b1);
      host.wr(TCS_ADDR_ONESHOT, 8'h5A);
      wait_busy(1'b1);
      cmp(cyc - t0, rate_cyc(k));
    end
    // Continuous mode runs sequences back to back.
    host.wr(TCS_ADDR_CONFIG, 8'h40);
    host.wr(TCS_ADDR_ENABLE, 8'h05);
    host.wr(TCS_ADDR_RATE, 8'h00);
    wait_busy(1'b0);
    host.wr(TCS_ADDR_CONFIG, 8'h00);
    wait_busy(1'b1);
    chk_seq(3'b101, 4'h5, 1'b0);
    fork
      chk_seq(3'b101, 4'h5, 1'b1);
      begin
        rd_cmp(TCS_ADDR_STATUS, 8'h80);
        host.wr(TCS_ADDR_CONFIG, 8'h40);
      end
    join
    quiet(40, n);
    cmp(n, 0);
    close_out();
  end

endmodule : tb_top

`default_nettype wire
